// ===== pcrc_top.sv
// Programmable CRC generator with AXI4-Lite register access
// ----------------------------------------------------------------
// Summary of operation
// RULE_01: Polynomials up to order 32; length from 5-bit field in control two.
// RULE_02: Each set term bit adds an XOR at that engine position.
// RULE_03: Constant term always XORed; lowest term bit not implemented.
// RULE_04: The Nth-order term is always used regardless of register bits.
// RULE_05: Software writes length 01111 or 11111 and sets present lower terms.
// RULE_06: Selectable shift direction, LSB first or MSB first.
// RULE_07: Word width and polynomial length are set independently.
// RULE_08: Interrupt output with a selectable trigger condition.
// RULE_09: Effective width and length are each field value plus one.
// RULE_10: Select 1 fires on FIFO empty while shifting; 0 on shift done.
// RULE_11: Clearing enable resets engine, FIFO, data, result; not other controls.
// RULE_12: Word count reports FIFO fill; max 8 when length field over 7, else 16.
// RULE_13: FIFO words shift through the engine in order while start is set.
// ----------------------------------------------------------------
//
// Register access over AXI4-Lite and the address map were chosen for this implementation.
`timescale 1ns/10ps
`include "pcrc_defines.svh"
module pcrc_top
    import pcrc_pkg::*;
#(
    parameter int DEPTH = `PCRC_FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // AXI4-Lite write
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Interrupt
    output logic             crc_irq_o
);
    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic        module_enable_q, irq_condition_select_q, shifter_start_q, lsb_first_select_q;
    logic [4:0]  word_width_field_q, poly_length_field_q;
    logic [15:0] poly_terms_low_q, poly_terms_high_q;
    pcrc_word_t  result_register_q;
    logic        aw_got_q, w_got_q;
    logic [11:0] awaddr_q;
    pcrc_word_t  wdata_q;
    logic [3:0]  wstrb_q;
    logic        irq_q, was_empty_q;

    // ------------------------------------------------------------
    // FIFO in memory plus a two-entry stage toward the engine
    // ------------------------------------------------------------
    pcrc_word_t  fifo_mem [DEPTH];
    logic [4:0]  rd_ptr_q, wr_ptr_q, fifo_word_count_q;
    wire  [4:0]  fifo_max = (poly_length_field_q > `PCRC_FIFO_DEEP_LEN) ?
                            `PCRC_FIFO_NARROW : `PCRC_FIFO_WIDE; // RULE_12
    wire         fifo_full  = (fifo_word_count_q >= fifo_max);
    wire         fifo_empty = (fifo_word_count_q == 5'd0);
    wire         flush      = !module_enable_q; // RULE_11

    // Write channel decode
    wire         wr_fire  = aw_got_q && w_got_q && !s_axi_bvalid;
    wire         wr_data  = wr_fire && (awaddr_q == `PCRC_OFS_DATA);
    wire         push     = wr_data && !fifo_full && module_enable_q;
    wire         stg_ready;
    wire         stg_valid;
    wire         eng_take;
    pcrc_word_t  stg_data;
    wire         pop      = !fifo_empty && stg_ready && shifter_start_q; // RULE_13

    pcrc_skid #(
        .WIDTH(32)
    ) u_stage (
        .clk_i      (clk_i),
        .rst_n_i    (rst_n_i),
        .flush_i    (flush),
        .in_valid_i (pop),
        .in_ready_o (stg_ready),
        .in_data_i  (fifo_mem[rd_ptr_q[3:0]]),
        .out_valid_o(stg_valid),
        .out_ready_i(eng_take),
        .out_data_o (stg_data)
    );

    function automatic logic [4:0] ptr_inc(input logic [4:0] p);
        ptr_inc = (p == 5'(DEPTH - 1)) ? 5'd0 : p + 5'd1;
    endfunction

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rd_ptr_q          <= 5'd0;
            wr_ptr_q          <= 5'd0;
            fifo_word_count_q <= 5'd0;
        end
        else if (flush)
        begin
            rd_ptr_q          <= 5'd0; // RULE_11
            wr_ptr_q          <= 5'd0;
            fifo_word_count_q <= 5'd0;
        end
        else
        begin
            if (push)
                wr_ptr_q <= ptr_inc(wr_ptr_q);
            if (pop)
                rd_ptr_q <= ptr_inc(rd_ptr_q);
            fifo_word_count_q <= fifo_word_count_q + {4'd0, push} - {4'd0, pop}; // RULE_12
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (push)
            fifo_mem[wr_ptr_q[3:0]] <= wdata_q;
    end

    // ------------------------------------------------------------
    // Shift engine, one bit per clock
    // ------------------------------------------------------------
    pcrc_state_e state_q;
    pcrc_word_t  shreg_q;
    logic [4:0]  bit_cnt_q;
    wire         eng_idle = (state_q == PCRC_IDLE);
    assign       eng_take = eng_idle && stg_valid && shifter_start_q;
    wire  [4:0]  top_bit  = poly_length_field_q; // RULE_09
    // Term mask: bit 0 forced, Nth term implicit as feedback
    wire  pcrc_word_t terms = {poly_terms_high_q, poly_terms_low_q[15:1], 1'b1}; // RULE_02 RULE_03
    wire  [4:0]  msb_pos  = word_width_field_q - bit_cnt_q; // RULE_07
    wire         in_bit   = lsb_first_select_q ? shreg_q[bit_cnt_q] : shreg_q[msb_pos]; // RULE_06
    wire         fb       = result_register_q[top_bit] ^ in_bit; // RULE_04
    wire  [31:0] len_mask = 32'hffffffff >> (5'd31 - top_bit); // RULE_01
    wire  pcrc_word_t crc_next = ({result_register_q[30:0], 1'b0} ^ (fb ? terms : 32'h0))
                                 & len_mask;
    wire         last_bit = (bit_cnt_q == word_width_field_q); // RULE_09

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_q           <= PCRC_IDLE;
            shreg_q           <= 32'h00000000;
            bit_cnt_q         <= 5'd0;
            result_register_q <= 32'h00000000;
        end
        else if (flush)
        begin
            state_q           <= PCRC_IDLE; // RULE_11
            bit_cnt_q         <= 5'd0;
            result_register_q <= 32'h00000000;
        end
        else if (wr_fire && awaddr_q == `PCRC_OFS_RESULT && eng_idle)
            result_register_q <= wdata_q; // Seed value
        else
        begin
            unique case (state_q)
                PCRC_IDLE:
                    if (eng_take)
                    begin
                        shreg_q   <= stg_data;
                        bit_cnt_q <= 5'd0;
                        state_q   <= PCRC_SHIFT; // RULE_13
                    end
                PCRC_SHIFT:
                begin
                    result_register_q <= crc_next;
                    bit_cnt_q         <= bit_cnt_q + 5'd1;
                    if (last_bit)
                        state_q <= PCRC_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Interrupt: one-cycle pulse on the selected event
    // ------------------------------------------------------------
    wire all_empty = fifo_empty && !stg_valid;
    wire done_ev   = (state_q == PCRC_SHIFT) && last_bit && all_empty;
    wire empty_ev  = all_empty && !was_empty_q && !eng_idle;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            irq_q       <= 1'b0;
            was_empty_q <= 1'b1;
        end
        else
        begin
            irq_q       <= module_enable_q && (irq_condition_select_q ? empty_ev : done_ev); // RULE_08 RULE_10
            was_empty_q <= all_empty;
        end
    end
    assign crc_irq_o = irq_q;

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    assign s_axi_awready = !aw_got_q;
    assign s_axi_wready  = !w_got_q;
    assign s_axi_arready = !s_axi_rvalid;
    assign s_axi_bresp   = 2'b00;
    assign s_axi_rresp   = 2'b00;

    wire [15:0] ctrl_one = {module_enable_q, 2'b00, fifo_word_count_q, fifo_full, fifo_empty,
                            irq_condition_select_q, shifter_start_q, lsb_first_select_q, 3'b000};
    wire [15:0] ctrl_two = {3'b000, word_width_field_q, 3'b000, poly_length_field_q};
    logic [31:0] rd_mux;
    always_comb
    begin
        unique case (s_axi_araddr)
            `PCRC_OFS_CTRL_ONE:   rd_mux = {16'h0000, ctrl_one};
            `PCRC_OFS_CTRL_TWO:   rd_mux = {16'h0000, ctrl_two};
            `PCRC_OFS_TERMS_LOW:  rd_mux = {16'h0000, poly_terms_low_q[15:1], 1'b0};
            `PCRC_OFS_TERMS_HIGH: rd_mux = {16'h0000, poly_terms_high_q};
            `PCRC_OFS_RESULT:     rd_mux = result_register_q;
            `PCRC_OFS_STATUS:     rd_mux = {30'h0, !eng_idle, stg_valid};
            default:              rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            aw_got_q     <= 1'b0;
            w_got_q      <= 1'b0;
            awaddr_q     <= 12'h000;
            wdata_q      <= 32'h00000000;
            wstrb_q      <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_got_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_got_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_fire)
                s_axi_bvalid <= 1'b1;
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                aw_got_q     <= 1'b0;
                w_got_q      <= 1'b0;
            end
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_mux;
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // Control registers survive enable clear; only the datapath is flushed
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            {module_enable_q, irq_condition_select_q} <= 2'b00;
            {shifter_start_q, lsb_first_select_q}     <= 2'b00;
            word_width_field_q  <= 5'd0;
            poly_length_field_q <= 5'd0;
            poly_terms_low_q    <= `PCRC_RST_TERMS;
            poly_terms_high_q   <= `PCRC_RST_TERMS;
        end
        else if (wr_fire)
        begin
            unique case (awaddr_q)
                `PCRC_OFS_CTRL_ONE:
                begin
                    if (wstrb_q[1])
                        module_enable_q <= wdata_q[`PCRC_BIT_ENABLE];
                    if (wstrb_q[0])
                    begin
                        irq_condition_select_q <= wdata_q[`PCRC_BIT_IRQ_SEL];
                        shifter_start_q        <= wdata_q[`PCRC_BIT_START];
                        lsb_first_select_q     <= wdata_q[`PCRC_BIT_LSB_FIRST];
                    end
                end
                `PCRC_OFS_CTRL_TWO:
                begin
                    if (wstrb_q[1])
                        word_width_field_q <= wdata_q[`PCRC_WIDTH_LSB +: 5]; // RULE_07
                    if (wstrb_q[0])
                        poly_length_field_q <= wdata_q[`PCRC_LEN_LSB +: 5]; // RULE_01
                end
                `PCRC_OFS_TERMS_LOW:
                begin
                    if (wstrb_q[0])
                        poly_terms_low_q[7:0] <= {wdata_q[7:1], 1'b0};
                    if (wstrb_q[1])
                        poly_terms_low_q[15:8] <= wdata_q[15:8];
                end
                `PCRC_OFS_TERMS_HIGH:
                begin
                    if (wstrb_q[0])
                        poly_terms_high_q[7:0] <= wdata_q[7:0];
                    if (wstrb_q[1])
                        poly_terms_high_q[15:8] <= wdata_q[15:8];
                end
                default:
                    ;
            endcase
        end
    end
endmodule

// ===== pcrc_defines.svh
// Register map, field positions, reset values and sizes of the CRC generator
`ifndef PCRC_DEFINES_SVH
`define PCRC_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PCRC_OFS_CTRL_ONE   12'h000
`define PCRC_OFS_CTRL_TWO   12'h004
`define PCRC_OFS_TERMS_LOW  12'h008
`define PCRC_OFS_TERMS_HIGH 12'h00c
`define PCRC_OFS_DATA       12'h010
`define PCRC_OFS_RESULT     12'h014
`define PCRC_OFS_STATUS     12'h018

// ----------------------------------------------------------------
// Control one field positions
// ----------------------------------------------------------------
`define PCRC_BIT_ENABLE     15
`define PCRC_BIT_FULL       7
`define PCRC_BIT_EMPTY      6
`define PCRC_BIT_IRQ_SEL    5
`define PCRC_BIT_START      4
`define PCRC_BIT_LSB_FIRST  3
`define PCRC_CNT_LSB        8

// ----------------------------------------------------------------
// Control two field positions
// ----------------------------------------------------------------
`define PCRC_WIDTH_LSB      8
`define PCRC_LEN_LSB        0

// ----------------------------------------------------------------
// Reset values and sizes
// ----------------------------------------------------------------
`define PCRC_RST_CTRL_ONE   16'h0000
`define PCRC_RST_CTRL_TWO   16'h0000
`define PCRC_RST_TERMS      16'h0000
`define PCRC_FIFO_DEPTH     16
`define PCRC_FIFO_DEEP_LEN  5'h07
`define PCRC_FIFO_NARROW    5'h08
`define PCRC_FIFO_WIDE      5'h10

`endif

// ===== pcrc_pkg.sv
// Types shared by the CRC generator
package pcrc_pkg;
    typedef enum logic [1:0] {PCRC_IDLE, PCRC_SHIFT} pcrc_state_e;
    typedef logic [31:0] pcrc_word_t;
endpackage

// ===== pcrc_skid.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
module pcrc_skid #(
    parameter int WIDTH = 32
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             flush_i,
    // Fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    logic [WIDTH-1:0] mem_q [2];
    logic             wp_q;
    logic             rp_q;
    logic [1:0]       cnt_q;
    wire              push = in_valid_i && in_ready_o;
    wire              pop  = out_valid_o && out_ready_i;

    assign in_ready_o  = (cnt_q != 2'd2);
    assign out_valid_o = (cnt_q != 2'd0);
    assign out_data_o  = mem_q[rp_q];

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wp_q  <= 1'b0;
            rp_q  <= 1'b0;
            cnt_q <= 2'd0;
        end
        else if (flush_i)
        begin
            wp_q  <= 1'b0;
            rp_q  <= 1'b0;
            cnt_q <= 2'd0;
        end
        else
        begin
            if (push)
                wp_q <= ~wp_q;
            if (pop)
                rp_q <= ~rp_q;
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (push)
            mem_q[wp_q] <= in_data_i;
    end
endmodule

// ===== pcrc_top_properties.sv
// Port-level assertions of the CRC generator and their bind
`timescale 1ns/10ps
`include "pcrc_defines.svh"
module pcrc_top_properties
    import pcrc_pkg::*;
#(
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    // Write channels
    input wire logic [11:0] s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    // Read channels
    input wire logic [11:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Interrupt
    input wire logic        crc_irq_o
);
    // Address of the read in flight, so read data can be judged by register
    logic [11:0] ra_q;
    logic        rd_c1;
    assign rd_c1 = s_axi_rvalid && ra_q == `PCRC_OFS_CTRL_ONE;
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            ra_q <= 12'h000;
        else if (s_axi_arvalid && s_axi_arready)
            ra_q <= s_axi_araddr;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
    chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    chk_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read data not held");
    chk_resp_okay: assert property (s_axi_bvalid || s_axi_rvalid |-> s_axi_bresp == 2'h0
        && s_axi_rresp == 2'h0) else $error("response code not okay");
    chk_irq_pulse: assert property (crc_irq_o |=> !crc_irq_o)
        else $error("interrupt longer than one cycle");
    chk_term_zero: assert property (s_axi_rvalid && ra_q == `PCRC_OFS_TERMS_LOW
        |-> s_axi_rdata[0] == 1'b0) else $error("lowest term bit reads set");
    chk_ctrl_two_fields: assert property (s_axi_rvalid && ra_q == `PCRC_OFS_CTRL_TWO
        |-> (s_axi_rdata & 32'hffffe0e0) == 32'h0) else $error("control two spare bits set");
    chk_count_limit: assert property (rd_c1 |-> s_axi_rdata[12:8] <= 5'h10
        && s_axi_rdata[6] == (s_axi_rdata[12:8] == 5'h00)) else $error("word count bad");
    cover property (crc_irq_o);
    cover property (s_axi_bvalid && s_axi_bready);
    cover property (rd_c1 && s_axi_rdata[7]);
endmodule
bind pcrc_top pcrc_top_properties #(.DEPTH(DEPTH)) i_pcrc_top_properties (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .crc_irq_o(crc_irq_o));

// ===== tb.sv
// Self-checking bench of the CRC generator
`timescale 1ns/10ps
`include "pcrc_defines.svh"
module tb;
    logic        clk_i, rst_n_i, crc_irq_o;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    int          fail_count = 0;
    int          checks_done = 0;
    int          irq_count = 0;
    initial
    begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    pcrc_top #(.DEPTH(16)) i_pcrc_top (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .crc_irq_o(crc_irq_o));
    always @(posedge clk_i)
        if (crc_irq_o === 1'b1)
            irq_count <= irq_count + 1;
    // ----------------------------------------------------------------
    // Bus tasks; ready is sampled mid-cycle, where it has settled
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            $display("unexpected %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic ta, tw, b;
        int   n;
        b = 1'b0;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!b && n < 100)
        begin
            @(negedge clk_i);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid;
            @(posedge clk_i);
            if (ta)
                s_axi_awvalid <= 1'b0;
            if (tw)
                s_axi_wvalid <= 1'b0;
            n++;
        end
        s_axi_bready <= 1'b0;
        @(posedge clk_i);
        if (!b)
            fail_count++;
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        logic ta, r;
        int   n;
        r = 1'b0;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!r && n < 100)
        begin
            @(negedge clk_i);
            ta = s_axi_arvalid && s_axi_arready;
            r = s_axi_rvalid;
            d = s_axi_rdata;
            @(posedge clk_i);
            if (ta)
                s_axi_arvalid <= 1'b0;
            n++;
        end
        s_axi_rready <= 1'b0;
        @(posedge clk_i);
        if (!r)
            fail_count++;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input string nm);
        logic [31:0] d;
        rd(a, d);
        chk(nm, e, d);
    endtask
    // Bit-serial reference: feedback from the top result bit, constant term always on
    function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [31:0] w,
        input logic [4:0] pl, input logic [4:0] wf, input logic ls, input logic [31:0] t);
        logic [31:0] m;
        logic        fb;
        m = 32'hffffffff >> (5'h1f - pl);
        for (int i = 0; i <= wf; i++)
        begin
            fb = c[pl] ^ (ls ? w[i] : w[wf - i]);
            c = (c << 1) & m;
            if (fb)
                c = c ^ ((t & m) | 32'h1);
        end
        return c;
    endfunction
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_regs;
        logic [11:0] a [7] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h014, 12'h018, 12'h0fc};
        logic [31:0] e [7] = '{32'h40, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
        foreach (a[i])
            rdchk(a[i], e[i], "reset value");
        wr(`PCRC_OFS_CTRL_TWO, 32'hffff);
        rdchk(`PCRC_OFS_CTRL_TWO, 32'h1f1f, "control two");
        wr(`PCRC_OFS_TERMS_LOW, 32'hffff);
        rdchk(`PCRC_OFS_TERMS_LOW, 32'hfffe, "terms low");
        wr(`PCRC_OFS_TERMS_HIGH, 32'hffff);
        rdchk(`PCRC_OFS_TERMS_HIGH, 32'hffff, "terms high");
        wr(12'h0fc, 32'hffff);
        rdchk(12'h0fc, 32'h0, "unmapped");
        $display("test registers done");
    endtask
    task automatic t_fill;
        wr(`PCRC_OFS_CTRL_ONE, 32'h0);
        wr(`PCRC_OFS_CTRL_TWO, 32'h070f);
        wr(`PCRC_OFS_CTRL_ONE, 32'h8000);
        for (int i = 0; i < 9; i++)
            wr(`PCRC_OFS_DATA, i);
        rdchk(`PCRC_OFS_CTRL_ONE, 32'h8880, "full at 8");
        wr(`PCRC_OFS_CTRL_ONE, 32'h0);
        wr(`PCRC_OFS_CTRL_TWO, 32'h0707);
        wr(`PCRC_OFS_CTRL_ONE, 32'h8000);
        for (int i = 0; i < 17; i++)
            wr(`PCRC_OFS_DATA, i);
        rdchk(`PCRC_OFS_CTRL_ONE, 32'h9080, "full at 16");
        wr(`PCRC_OFS_RESULT, 32'h5a);
        rdchk(`PCRC_OFS_RESULT, 32'h5a, "seeded result");
        wr(`PCRC_OFS_CTRL_ONE, 32'h0);
        rdchk(`PCRC_OFS_CTRL_ONE, 32'h40, "flushed");
        rdchk(`PCRC_OFS_CTRL_TWO, 32'h0707, "kept control");
        rdchk(`PCRC_OFS_RESULT, 32'h0, "cleared result");
        $display("test fill and flush done");
    endtask
    task automatic run_crc(input logic [4:0] pl, input logic [4:0] wf, input logic ls,
        input logic is, input logic [31:0] t, input logic [31:0] w0, input logic [31:0] w1);
        logic [31:0] ws [3];
        logic [31:0] c, cfg, d;
        int          k, n;
        ws = '{w0, w1, w0 ^ w1};
        c = 32'h0;
        cfg = {16'h0, 1'b1, 9'h0, is, 1'b0, ls, 3'h0};
        wr(`PCRC_OFS_CTRL_ONE, 32'h0);
        wr(`PCRC_OFS_CTRL_TWO, {19'h0, wf, 3'h0, pl});
        wr(`PCRC_OFS_TERMS_LOW, {16'h0, t[15:0]});
        wr(`PCRC_OFS_TERMS_HIGH, {16'h0, t[31:16]});
        wr(`PCRC_OFS_CTRL_ONE, cfg);
        foreach (ws[i])
        begin
            wr(`PCRC_OFS_DATA, ws[i]);
            c = crc_step(c, ws[i], pl, wf, ls, t);
        end
        rdchk(`PCRC_OFS_CTRL_ONE, cfg | 32'h300, "words held");
        k = irq_count;
        n = 0;
        wr(`PCRC_OFS_CTRL_ONE, cfg | 32'h10);
        while (irq_count == k && n < 2000)
        begin
            @(posedge clk_i);
            n++;
        end
        rd(`PCRC_OFS_STATUS, d);
        chk("status at interrupt", {30'h0, is, 1'b0}, d);
        n = 0;
        while (d[1] !== 1'b0 && n < 100)
        begin
            rd(`PCRC_OFS_STATUS, d);
            n++;
        end
        chk("interrupt count", k + 1, irq_count);
        rdchk(`PCRC_OFS_RESULT, c, "crc result");
        $display("test crc length field %0d done", pl);
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
        s_axi_wstrb = 4'hf;
        rst_n_i = 1'b0;
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        t_regs();
        t_fill();
        run_crc(5'h0f, 5'h07, 1'b0, 1'b0, 32'h0000_1020, 32'h31, 32'ha5);
        run_crc(5'h1f, 5'h1f, 1'b1, 1'b0, 32'h04c1_1db6, 32'h1234_5678, 32'hdead_beef);
        run_crc(5'h07, 5'h0f, 1'b1, 1'b1, 32'h0000_0006, 32'hc3a5, 32'h8001);
        report_and_stop();
    end
    initial
    begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        report_and_stop();
    end
endmodule
